/* smic_core.sv */
// smic_core: memory access command interpreter, tristate gating, hdlc set-up gating
// assumes host writes arrive synchronous to clk as one-cycle strobes
`timescale 1ns/100ps
// Function
// [R1] reset leaves memory contents unchanged
// [R2] reset command writes unassigned code everywhere
// [R3] host keeps mode zero during memory reset
// [R4] memory reset takes 256 cycles, busy set
// [R5] host polls busy before next command
// [R6] host programs last two slots per channel
// [R7] even slot monitor, odd slot signaling variants
// [R8] host uses codes A/B for arbiter downstream
// [R9] upstream arbiter accepts any preprocessed code
// [R10] code 8 compares received value to data
// [R11] init mode single access within 2.5 cycles
// [R12] tristate zero floats, fifteen drives slot
// [R13] tristate reset fills field, 1035 cycles
// [R14] standby zero floats every pcm driver
// [R15] host writes hdlc mode register first
// [R16] host loads address registers per mode
// [R17] host writes config two before one
// [R18] power-down stops clocks and interrupts
// [R19] host resets transmitter and receiver after power-up
// [R20] host writes blocking pattern in even data
// [R21] host activates blocked subscribers with 1100
// [R22] clock mode 3 uses arbiter, pin optional
// [R23] destination or broadcast group steers output
// [R24] receiver reset clears idle-abort interrupt; an idle-abort event in the same cycle outside power-down sets it instead
// [R25] command low nibble picks stored channel code
module smic_core #(
  parameter int ADDR_W = 8,
  parameter int SUBS = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] memory_data_reg,
  input wire logic [7:0] memory_location_reg,
  input wire logic [7:0] memory_command_reg,
  input wire logic memory_command_wr,
  input wire logic [1:0] operation_mode_select,
  input wire logic pcm_output_standby,
  input wire logic [ADDR_W-1:0] pcm_slot,
  input wire logic [7:0] pcm_slot_data,
  output logic pcm_out_data,
  output logic pcm_out_oe,
  input wire logic [ADDR_W-1:0] cfi_slot,
  input wire logic [3:0] cfi_rx_ci,
  output logic ci_mismatch,
  output logic arb_slot,
  output logic [3:0] cfi_slot_code,
  output logic [7:0] cfi_slot_data,
  output logic memory_access_busy_flag,
  input wire logic power_down,
  input wire logic [1:0] clock_mode,
  input wire logic transmit_pin_enable,
  input wire logic hdlc_tx_bit,
  input wire logic [2:0] transmit_destination_reg,
  input wire logic broadcast_bit,
  input wire logic [SUBS-1:0] broadcast_group_regs,
  output logic [SUBS-1:0] sub_tx_select,
  output logic transmit_pin_data,
  input wire logic idle_abort_event,
  input wire logic receiver_reset_cmd,
  output logic hdlc_irq
);
  // memories carry no reset so their contents survive a hardware reset
  logic [3:0] cm_code [smic_pkg::CM_DEPTH]; // R1
  logic [7:0] cm_data [smic_pkg::CM_DEPTH];
  logic [3:0] ts_field [smic_pkg::TS_DEPTH];

  smic_pkg::smic_state_t state_q, state_d;
  logic [10:0] cnt_q, cnt_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [3:0] wcode_q, wcode_d;
  logic busy_q, busy_d;
  logic ida_q, ida_d;
  logic [3:0] rd_code_q;
  logic [7:0] rd_data_q;
  logic ts_q, pcm_data_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    wcode_d = wcode_q;
    busy_d = busy_q;
    case (state_q)
      smic_pkg::SMIC_IDLE: begin
        if (memory_command_wr) begin
          addr_d = memory_location_reg;
          wdata_d = memory_data_reg;
          wcode_d = memory_command_reg[3:0]; // R25
          busy_d = 1'b1;
          if (memory_command_reg == smic_pkg::CMD_TS_RESET
              && operation_mode_select == smic_pkg::OMS_NORMAL) begin
            state_d = smic_pkg::SMIC_TS_CLR; // R13
            cnt_d = 11'(smic_pkg::TS_RESET_CYCLES - 1);
            addr_d = 8'h00;
          end else if (memory_command_reg[7:4] == smic_pkg::CMD_CM_RESET
              && operation_mode_select == smic_pkg::OMS_CM_RESET) begin
            state_d = smic_pkg::SMIC_CM_CLR; // R2
            cnt_d = 11'(smic_pkg::CM_RESET_CYCLES - 1);
            addr_d = 8'h00;
          end else begin
            state_d = smic_pkg::SMIC_SINGLE;
            cnt_d = (operation_mode_select == smic_pkg::OMS_CM_INIT) ?
              11'(smic_pkg::SINGLE_ACC_CYCLES - 1) : // R11
              11'(smic_pkg::NORMAL_ACC_CYCLES - 1);
          end
        end
      end
      smic_pkg::SMIC_CM_CLR, smic_pkg::SMIC_TS_CLR, smic_pkg::SMIC_SINGLE: begin
        addr_d = (state_q == smic_pkg::SMIC_SINGLE) ? addr_q : addr_q + 8'h01;
        if (cnt_q == 11'h000) begin
          state_d = smic_pkg::SMIC_IDLE;
          busy_d = 1'b0; // R4
        end else begin
          cnt_d = cnt_q - 11'h001;
        end
      end
      default: state_d = smic_pkg::SMIC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= smic_pkg::SMIC_IDLE;
      cnt_q <= 11'h000;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      wcode_q <= 4'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wcode_q <= wcode_d;
      busy_q <= busy_d;
    end
  end

  // memory writes; the tristate sweep runs longer than the field and simply wraps
  always_ff @(posedge clk) begin
    if (state_q == smic_pkg::SMIC_CM_CLR) begin
      cm_code[addr_q] <= smic_pkg::CODE_UNASSIGNED; // R2
      cm_data[addr_q] <= wdata_q;
    end
    if (state_q == smic_pkg::SMIC_SINGLE && cnt_q == 11'h000) begin
      cm_code[addr_q] <= wcode_q; // R25
      cm_data[addr_q] <= wdata_q;
    end
    if (state_q == smic_pkg::SMIC_TS_CLR) begin
      ts_field[addr_q] <= wdata_q[3:0]; // R13
    end
    rd_code_q <= cm_code[cfi_slot];
    rd_data_q <= cm_data[cfi_slot];
    ts_q <= (ts_field[pcm_slot] == smic_pkg::TS_DRIVE); // R12
    pcm_data_q <= pcm_slot_data[7];
  end

  assign memory_access_busy_flag = busy_q; // R4
  assign cfi_slot_code = rd_code_q;
  assign cfi_slot_data = rd_data_q;
  // even slot code 8 holds the expected command/indicate value in data bits 5..2
  assign ci_mismatch = (rd_code_q == smic_pkg::CODE_CI_COMPARE) &&
    (cfi_rx_ci != rd_data_q[5:2]); // R10
  assign arb_slot = (rd_code_q == smic_pkg::CODE_ARB_EVEN) ||
    (rd_code_q == smic_pkg::CODE_ARB_ODD) || (rd_code_q[3] && cfi_slot[7]); // R7 R9
  assign pcm_out_oe = pcm_output_standby && ts_q; // R12 R14
  assign pcm_out_data = pcm_data_q;

  // hdlc side: destination decode, pin mirror, idle-abort flag
  always_comb begin
    sub_tx_select = '0;
    if (!power_down && clock_mode == smic_pkg::CLK_MODE_ARB) begin
      if (broadcast_bit) sub_tx_select = broadcast_group_regs; // R23
      else sub_tx_select[transmit_destination_reg] = 1'b1; // R23
    end
    ida_d = ida_q;
    if (receiver_reset_cmd) ida_d = 1'b0; // R24
    if (idle_abort_event && !power_down) ida_d = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ida_q <= 1'b0;
      transmit_pin_data <= 1'b1;
    end else begin
      ida_q <= ida_d;
      if (!power_down) begin // R18
        transmit_pin_data <= (clock_mode == smic_pkg::CLK_MODE_ARB && !transmit_pin_enable) ?
          1'b1 : hdlc_tx_bit; // R22
      end
    end
  end

  assign hdlc_irq = ida_q && !power_down; // R18

  // sweep length watch for the tristate reset; too long for a delay range
  logic [10:0] ts_run_q, ts_run_d;
  always_comb begin
    ts_run_d = (state_q == smic_pkg::SMIC_TS_CLR) ? ts_run_q + 11'h001 : 11'h000;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ts_run_q <= 11'h000;
    end else begin
      ts_run_q <= ts_run_d;
    end
  end

  // the strobe that opens the control memory sweep
  sequence cm_reset_start_s;
    state_q == smic_pkg::SMIC_IDLE && state_d == smic_pkg::SMIC_CM_CLR;
  endsequence

  cm_busy_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
    cm_reset_start_s |=> memory_access_busy_flag [*8])
    else $error("busy dropped during memory reset");
  cm_done_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
    cm_reset_start_s |=> ##255 memory_access_busy_flag ##1 !memory_access_busy_flag)
    else $error("memory reset length wrong");
  init_fast_a: assert property (@(posedge clk) disable iff (!reset_n) // R11
    (state_q == smic_pkg::SMIC_IDLE && memory_command_wr &&
     state_d == smic_pkg::SMIC_SINGLE && operation_mode_select == smic_pkg::OMS_CM_INIT)
    |=> ##[1:2] !memory_access_busy_flag)
    else $error("init access too slow");
  ts_done_a: assert property (@(posedge clk) disable iff (!reset_n) // R13
    ts_run_q <= 11'(smic_pkg::TS_RESET_CYCLES))
    else $error("tristate reset too slow");
  standby_float_a: assert property (@(posedge clk) disable iff (!reset_n) // R14
    !pcm_output_standby |-> !pcm_out_oe)
    else $error("pcm driven in standby");
  ida_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // R24
    (receiver_reset_cmd && !idle_abort_event) |=> !hdlc_irq)
    else $error("idle-abort not cleared");
  pd_irq_a: assert property (@(posedge clk) disable iff (!reset_n) // R18
    power_down |-> !hdlc_irq)
    else $error("interrupt in power-down");
  bcast_a: assert property (@(posedge clk) disable iff (!reset_n) // R23
    (broadcast_bit && !power_down && clock_mode == smic_pkg::CLK_MODE_ARB)
    |-> sub_tx_select == broadcast_group_regs)
    else $error("broadcast select wrong");
endmodule : smic_core

/* smic_pkg.sv */
// smic_pkg: constants for the switch memory init control block
// assumes one 125 MHz clock that also stands in for the reference clock
package smic_pkg;
  localparam int CM_DEPTH = 256;
  localparam int TS_DEPTH = 256;
  localparam int CM_RESET_CYCLES = 256;
  localparam int TS_RESET_CYCLES = 1035;
  // 2.5 reference cycles rounded down, never below one
  localparam int SINGLE_ACC_TENTHS = 25;
  localparam int SINGLE_ACC_CYCLES = (SINGLE_ACC_TENTHS / 10 < 1) ? 1 : SINGLE_ACC_TENTHS / 10;
  localparam int NORMAL_ACC_CYCLES = 8;
  localparam logic [3:0] CMD_CM_RESET = 4'h7;
  localparam logic [7:0] CMD_TS_RESET = 8'h68;
  localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
  localparam logic [3:0] CODE_CI_COMPARE = 4'h8;
  localparam logic [3:0] CODE_ARB_EVEN = 4'hA;
  localparam logic [3:0] CODE_ARB_ODD = 4'hB;
  localparam logic [3:0] TS_HIGHZ = 4'h0;
  localparam logic [3:0] TS_DRIVE = 4'hF;
  localparam logic [1:0] OMS_CM_RESET = 2'h0;
  localparam logic [1:0] OMS_CM_INIT = 2'h2;
  localparam logic [1:0] OMS_NORMAL = 2'h3;
  localparam logic [1:0] CLK_MODE_ARB = 2'h3;
  typedef enum logic [1:0] {
    SMIC_IDLE = 2'b00,
    SMIC_CM_CLR = 2'b01,
    SMIC_TS_CLR = 2'b10,
    SMIC_SINGLE = 2'b11
  } smic_state_t;
endpackage : smic_pkg

/* smic_host.sv */
// smic_host: host model issuing memory access commands as one-cycle strobes
// assumes busy rises on the edge after the strobe and stays up until done
`timescale 1ns/100ps
module smic_host (
  input wire logic clk,
  input wire logic busy,
  output logic [7:0] data,
  output logic [7:0] loc,
  output logic [7:0] cmd,
  output logic wr,
  output logic [1:0] mode
);
  initial begin
    data = 8'h00;
    loc = 8'h00;
    cmd = 8'h00;
    wr = 1'b0;
    mode = 2'h0;
  end
  task automatic issue(input logic [7:0] d, input logic [7:0] l, input logic [7:0] c,
                       input logic [1:0] m, output int n);
    @(negedge clk);
    mode = m;
    data = d;
    loc = l;
    cmd = c;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    // released values are scrambled so a late sample cannot pass by luck
    data = ~d;
    loc = ~l;
    cmd = ~c;
    n = 0;
    for (int i = 0; i < 2000; i++) begin
      if (busy === 1'b1) n++;
      else if (n > 0) break;
      @(negedge clk);
    end
  endtask : issue
endmodule : smic_host

/* smic_core_bench.sv */
// smic_core_bench: self-checking bench for the memory init command block
// assumes the host model drives the command port and the bench the rest
`timescale 1ns/100ps
module smic_core_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] md, ml, mc, pcm_slot = 8'h00, pcm_slot_data = 8'h00, cfi_slot = 8'h00;
  logic [7:0] sub_tx_select, cfi_slot_data, broadcast_group_regs = 8'h00;
  logic [3:0] cfi_rx_ci = 4'h0, cfi_slot_code;
  logic [2:0] transmit_destination_reg = 3'h0;
  logic [1:0] mode, clock_mode = 2'h0;
  logic mw, busy, pcm_out_data, pcm_out_oe, ci_mismatch, arb_slot, transmit_pin_data, hdlc_irq;
  logic pcm_output_standby = 1'b0, power_down = 1'b0, transmit_pin_enable = 1'b0;
  logic hdlc_tx_bit = 1'b1, broadcast_bit = 1'b0, idle_abort_event = 1'b0;
  logic receiver_reset_cmd = 1'b0;
  int errors = 0;
  int tests_run = 0;
  int n;
  always #4 clk = ~clk;
  smic_host host (.clk(clk), .busy(busy), .data(md), .loc(ml), .cmd(mc), .wr(mw), .mode(mode));
  smic_core DUT (.clk(clk), .reset_n(reset_n), .memory_data_reg(md), .memory_location_reg(ml),
    .memory_command_reg(mc), .memory_command_wr(mw), .operation_mode_select(mode),
    .pcm_output_standby(pcm_output_standby), .pcm_slot(pcm_slot), .pcm_slot_data(pcm_slot_data),
    .pcm_out_data(pcm_out_data), .pcm_out_oe(pcm_out_oe), .cfi_slot(cfi_slot),
    .cfi_rx_ci(cfi_rx_ci), .ci_mismatch(ci_mismatch), .arb_slot(arb_slot),
    .cfi_slot_code(cfi_slot_code), .cfi_slot_data(cfi_slot_data),
    .memory_access_busy_flag(busy), .power_down(power_down), .clock_mode(clock_mode),
    .transmit_pin_enable(transmit_pin_enable), .hdlc_tx_bit(hdlc_tx_bit),
    .transmit_destination_reg(transmit_destination_reg), .broadcast_bit(broadcast_bit),
    .broadcast_group_regs(broadcast_group_regs), .sub_tx_select(sub_tx_select),
    .transmit_pin_data(transmit_pin_data), .idle_abort_event(idle_abort_event),
    .receiver_reset_cmd(receiver_reset_cmd), .hdlc_irq(hdlc_irq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step
  task automatic rd(input logic [7:0] l);
    @(negedge clk);
    cfi_slot = l;
    step(1);
  endtask : rd
  task automatic t_cm_reset();
    host.issue(8'hFF, 8'h00, 8'h70, 2'h0, n);
    check(16'(n), 16'(smic_pkg::CM_RESET_CYCLES));
    rd(8'h00);
    check(16'(cfi_slot_code), 16'h0000);
    rd(8'hFF);
    check(16'(cfi_slot_code), 16'h0000);
  endtask : t_cm_reset
  task automatic t_single();
    host.issue(8'hF1, 8'h08, 8'h7A, 2'h2, n);
    check(16'(n), 16'(smic_pkg::SINGLE_ACC_CYCLES));
    host.issue(8'hFF, 8'h09, 8'h7B, 2'h2, n);
    host.issue(8'hFF, 8'h88, 8'h78, 2'h3, n);
    check(16'(n), 16'(smic_pkg::NORMAL_ACC_CYCLES));
    rd(8'h08);
    check(16'({cfi_slot_code, cfi_slot_data}), 16'h0AF1);
    rd(8'h09);
    check(16'(cfi_slot_code), 16'h000B);
    cfi_rx_ci = 4'hF;
    rd(8'h88);
    check(16'({arb_slot, ci_mismatch}), 16'h0002);
    cfi_rx_ci = 4'h0;
    step(1);
    check(16'(ci_mismatch), 16'h0001);
  endtask : t_single
  task automatic t_tristate();
    host.issue(8'h0F, 8'h00, 8'h68, 2'h3, n);
    check(16'(n), 16'(smic_pkg::TS_RESET_CYCLES));
    pcm_output_standby = 1'b1;
    pcm_slot = 8'h05;
    pcm_slot_data = 8'h80;
    step(2);
    check(16'({pcm_out_oe, pcm_out_data}), 16'h0003);
    pcm_output_standby = 1'b0;
    step(1);
    check(16'(pcm_out_oe), 16'h0000);
    host.issue(8'h00, 8'h00, 8'h68, 2'h3, n);
    pcm_output_standby = 1'b1;
    step(2);
    check(16'(pcm_out_oe), 16'h0000);
  endtask : t_tristate
  task automatic t_keep();
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    rd(8'h08);
    check(16'({busy, cfi_slot_code}), 16'h000A);
  endtask : t_keep
  task automatic t_hdlc();
    // mode and address registers are loaded outside this block while powered down
    power_down = 1'b1;
    transmit_pin_enable = 1'b0;
    step(1);
    clock_mode = 2'h3;
    power_down = 1'b0;
    transmit_destination_reg = 3'h3;
    step(1);
    check(16'(sub_tx_select), 16'h0008);
    broadcast_bit = 1'b1;
    broadcast_group_regs = 8'hA5;
    transmit_pin_enable = 1'b1;
    hdlc_tx_bit = 1'b0;
    step(2);
    check(16'({sub_tx_select, transmit_pin_data}), 16'h014A);
    transmit_pin_enable = 1'b0;
    power_down = 1'b1;
    idle_abort_event = 1'b1;
    step(1);
    idle_abort_event = 1'b0;
    step(2);
    check(16'({transmit_pin_data, hdlc_irq}), 16'h0000);
    power_down = 1'b0;
    idle_abort_event = 1'b1;
    step(1);
    idle_abort_event = 1'b0;
    step(2);
    check(16'({transmit_pin_data, hdlc_irq}), 16'h0003);
    receiver_reset_cmd = 1'b1;
    step(1);
    receiver_reset_cmd = 1'b0;
    step(2);
    check(16'(hdlc_irq), 16'h0000);
  endtask : t_hdlc
  task automatic summarize();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    // the whole sequence needs well under 3000 cycles
    #200000;
    errors++;
    summarize();
  end
  initial begin
    step(10);
    reset_n = 1'b1;
    t_cm_reset();
    t_single();
    t_tristate();
    t_keep();
    t_hdlc();
    summarize();
  end
endmodule : smic_core_bench
